// ---- logic/synth_pkg.sv ----
package synth_pkg;
  localparam int unsigned AUX_W = 12;
  localparam int unsigned MAIN_W = 12;
  localparam int unsigned SHORT_W = 4;
  localparam int unsigned SECOND2_W = 8;
  localparam int unsigned GAIN_W = 8;
  localparam int unsigned SPEED_W = 2;
  localparam int unsigned INTMUL_W = 4;
  localparam int unsigned CUR_W = 16;
  localparam logic [11:0] AUX_MIN_RATIO = 12'h003;
  localparam logic [11:0] RESET_RATIO = 12'h003;
  localparam logic [1:0] MODE_TWO = 2'h0;
  localparam logic [1:0] MODE_THREE = 2'h1;
  localparam logic [1:0] MODE_FOUR = 2'h2;
  localparam logic [1:0] SEL_FIRST = 2'h0;
  localparam logic [1:0] SEL_SECOND = 2'h1;
  localparam logic [1:0] SEL_THIRD = 2'h2;
  localparam logic [1:0] SEL_FOURTH = 2'h3;

  typedef enum logic [1:0] {
    PH_FIRST = 2'b00,
    PH_SECOND = 2'b01,
    PH_THIRD = 2'b10,
    PH_FOURTH = 2'b11
  } phase_t;

  typedef struct packed {
    logic up;
    logic down;
  } pump_t;

  typedef struct packed {
    logic [1:0] mode;
    logic [11:0] first_ratio_count;
    logic [7:0] second_ratio_count;
    logic [3:0] third_end;
    logic [3:0] fourth_end;
  } main_cfg_t;

  typedef struct packed {
    logic [7:0] gain_code;
    logic [1:0] speed_code;
    logic [3:0] int_mult;
  } pump_cfg_t;
endpackage

// ---- logic/pfd_core.sv ----
module pfd_core (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic enable_i,
  input wire logic ref_edge_i,
  input wire logic fb_edge_i,
  output synth_pkg::pump_t pump_o
);
  logic up;
  logic down;
  logic next_up;
  logic next_down;

  // Two flip-flops cleared together in the cycle both would be set, so never both high; edges in one cycle give no pulse
  always_comb
  begin
    next_up = up | ref_edge_i;
    next_down = down | fb_edge_i;
    if (!enable_i)
    begin
      next_up = 1'b0;
      next_down = 1'b0;
    end
    else if (next_up && next_down)
    begin
      next_up = 1'b0;
      next_down = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      up <= 1'b0;
      down <= 1'b0;
    end
    else
    begin
      up <= next_up;
      down <= next_down;
    end
  end

  assign pump_o.up = up;
  assign pump_o.down = down;
endmodule

// ---- logic/dual_pll_divider_core.sv ----
module dual_pll_divider_core (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic aux_clk_en_i,
  input wire logic [11:0] aux_ratio_i,
  input wire logic aux_standby_i,
  input wire logic [3:0] ref_taps_i,
  input wire logic [1:0] aux_tap_sel_i,
  input wire logic [1:0] main_tap_sel_i,
  input wire logic prescaler_edge_i,
  input wire synth_pkg::main_cfg_t main_cfg_i,
  input wire logic fractional_i,
  input wire synth_pkg::pump_cfg_t pump_cfg_i,
  input wire logic strobe_i,
  input wire logic word_a_sel_i,
  output synth_pkg::pump_t aux_pump_out_o,
  output synth_pkg::pump_t proportional_pump_out_o,
  output synth_pkg::pump_t integral_pump_out_o,
  output logic [15:0] proportional_pump_current_o,
  output logic [15:0] integral_pump_current_o,
  output logic prescaler_select_a_o,
  output logic prescaler_select_b_o,
  output logic main_cycle_o,
  output logic aux_cycle_o
);
  // Aux divider
  logic [11:0] aux_count;
  logic [11:0] next_aux_count;
  logic aux_cycle;
  logic next_aux_cycle;
  logic [11:0] aux_load;

  // Ratios below the minimum are clamped rather than stalling the loop
  always_comb
  begin
    aux_load = (aux_ratio_i < synth_pkg::AUX_MIN_RATIO) ? synth_pkg::AUX_MIN_RATIO
                                                          : aux_ratio_i;
    next_aux_count = aux_count;
    next_aux_cycle = 1'b0;
    if (aux_standby_i)
    begin
      next_aux_count = aux_load - 12'h001;
    end
    else if (aux_clk_en_i)
    begin
      if (aux_count == 12'h000)
      begin
        next_aux_count = aux_load - 12'h001;
        next_aux_cycle = 1'b1;
      end
      else
      begin
        next_aux_count = aux_count - 12'h001;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      aux_count <= synth_pkg::RESET_RATIO;
      aux_cycle <= 1'b0;
    end
    else
    begin
      aux_count <= next_aux_count;
      aux_cycle <= next_aux_cycle;
    end
  end

  // Reference taps and their edges
  logic aux_ref;
  logic main_ref;
  logic aux_ref_d;
  logic main_ref_d;
  logic next_aux_ref_d;
  logic next_main_ref_d;

  always_comb
  begin
    aux_ref = ref_taps_i[aux_tap_sel_i];
    main_ref = ~ref_taps_i[main_tap_sel_i];
    next_aux_ref_d = aux_ref;
    next_main_ref_d = main_ref;
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      aux_ref_d <= 1'b0;
      main_ref_d <= 1'b0;
    end
    else
    begin
      aux_ref_d <= next_aux_ref_d;
      main_ref_d <= next_main_ref_d;
    end
  end

  pfd_core aux_pfd (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .enable_i(~aux_standby_i),
    .ref_edge_i(aux_ref & ~aux_ref_d),
    .fb_edge_i(aux_cycle),
    .pump_o(aux_pump_out_o)
  );

  // Main up/down divider
  synth_pkg::phase_t phase;
  synth_pkg::phase_t next_phase;
  logic [11:0] main_count;
  logic [11:0] next_main_count;
  logic main_cycle;
  logic next_main_cycle;
  logic frac_pending;
  logic next_frac_pending;
  logic [11:0] second_end;
  logic [3:0] up_low;
  logic second_done;

  always_comb
  begin
    // Two-modulus span is 8 bits; other modes use the low 4 bits only
    if (main_cfg_i.mode == synth_pkg::MODE_TWO)
    begin
      second_end = {4'h0, main_cfg_i.second_ratio_count};
    end
    else
    begin
      second_end = {8'h00, main_cfg_i.second_ratio_count[3:0]};
    end
    up_low = main_count[3:0] + 4'h1;
    // Done when the up count reaches its end; end zero wraps a full 16
    // All ones marks the extra fractional cycle, which never ends the span
    second_done = main_count != 12'hFFF
                  && ((main_count + 12'h001) == second_end
                  || (second_end == 12'h000 && main_count == 12'h00F));
    next_phase = phase;
    next_main_count = main_count;
    next_main_cycle = 1'b0;
    next_frac_pending = frac_pending | fractional_i;
    if (prescaler_edge_i)
    begin
      case (phase)
        synth_pkg::PH_FIRST:
        begin
          if (main_count <= 12'h001)
          begin
            next_phase = synth_pkg::PH_SECOND;
            next_main_count = 12'h000;
          end
          else if (frac_pending && main_count == 12'h002)
          begin
            // Last first-ratio cycle becomes one extra second-ratio cycle
            next_phase = synth_pkg::PH_SECOND;
            next_main_count = 12'hFFF;
            next_frac_pending = fractional_i;
          end
          else
          begin
            next_main_count = main_count - 12'h001;
          end
        end
        synth_pkg::PH_SECOND:
        begin
          if (second_done)
          begin
            next_main_count = main_count + 12'h001;
            if (main_cfg_i.mode == synth_pkg::MODE_TWO)
            begin
              next_phase = synth_pkg::PH_FIRST;
              next_main_count = main_cfg_i.first_ratio_count;
              next_main_cycle = 1'b1;
            end
            else
            begin
              next_phase = synth_pkg::PH_THIRD;
            end
          end
          else
          begin
            next_main_count = main_count + 12'h001;
          end
        end
        synth_pkg::PH_THIRD:
        begin
          next_main_count = main_count + 12'h001;
          if (up_low == main_cfg_i.third_end)
          begin
            if (main_cfg_i.mode == synth_pkg::MODE_FOUR)
            begin
              next_phase = synth_pkg::PH_FOURTH;
            end
            else
            begin
              next_phase = synth_pkg::PH_FIRST;
              next_main_count = main_cfg_i.first_ratio_count;
              next_main_cycle = 1'b1;
            end
          end
        end
        synth_pkg::PH_FOURTH:
        begin
          next_main_count = main_count + 12'h001;
          if (up_low == main_cfg_i.fourth_end)
          begin
            next_phase = synth_pkg::PH_FIRST;
            next_main_count = main_cfg_i.first_ratio_count;
            next_main_cycle = 1'b1;
          end
        end
        default:
        begin
          next_phase = synth_pkg::PH_FIRST;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      phase <= synth_pkg::PH_FIRST;
      main_count <= synth_pkg::RESET_RATIO;
      main_cycle <= 1'b0;
      frac_pending <= 1'b0;
    end
    else
    begin
      phase <= next_phase;
      main_count <= next_main_count;
      main_cycle <= next_main_cycle;
      frac_pending <= next_frac_pending;
    end
  end

  // Select code follows phase register, so it changes with the phase
  assign prescaler_select_a_o = phase[0];
  assign prescaler_select_b_o = phase[1];

  synth_pkg::pump_t main_pump;

  pfd_core main_pfd (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .enable_i(1'b1),
    .ref_edge_i(main_ref & ~main_ref_d),
    .fb_edge_i(main_cycle),
    .pump_o(main_pump)
  );

  // Pump currents in units of the resistor-derived base step
  logic speed_up;
  logic next_speed_up;
  logic strobe_d;
  logic next_strobe_d;
  logic [15:0] prop_cur;
  logic [15:0] int_cur;
  logic [15:0] next_prop_cur;
  logic [15:0] next_int_cur;
  logic [15:0] base_cur;
  logic [15:0] fast_cur;

  always_comb
  begin
    next_strobe_d = strobe_i;
    next_speed_up = speed_up;
    if (!strobe_i)
    begin
      next_speed_up = 1'b0;
    end
    else if (!strobe_d && word_a_sel_i)
    begin
      next_speed_up = 1'b1;
    end
    base_cur = {8'h00, pump_cfg_i.gain_code};
    // Widened so code 3 does not wrap to a shift of zero
    fast_cur = 16'(base_cur << ({1'b0, pump_cfg_i.speed_code} + 3'h1));
    next_prop_cur = speed_up ? fast_cur : base_cur;
    // Top product, 255 shifted by 4 then times 15, is 61200 and still fits in 16 bits
    next_int_cur = speed_up ? 16'(fast_cur * pump_cfg_i.int_mult) : 16'h0000;
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      strobe_d <= 1'b0;
      speed_up <= 1'b0;
      prop_cur <= 16'h0000;
      int_cur <= 16'h0000;
    end
    else
    begin
      strobe_d <= next_strobe_d;
      speed_up <= next_speed_up;
      prop_cur <= next_prop_cur;
      int_cur <= next_int_cur;
    end
  end

  assign proportional_pump_out_o = main_pump;
  assign integral_pump_out_o.up = main_pump.up & speed_up;
  assign integral_pump_out_o.down = main_pump.down & speed_up;
  assign proportional_pump_current_o = prop_cur;
  assign integral_pump_current_o = int_cur;
  assign main_cycle_o = main_cycle;
  assign aux_cycle_o = aux_cycle;
endmodule

// ---- test/dual_pll_divider_core_sva.sv ----
module dual_pll_divider_core_sva (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic strobe_i,
  input wire logic word_a_sel_i,
  input wire logic aux_standby_i,
  input wire logic prescaler_edge_i,
  input wire synth_pkg::pump_cfg_t pump_cfg_i,
  input wire synth_pkg::pump_t aux_pump_out_o,
  input wire logic [15:0] proportional_pump_current_o,
  input wire logic [15:0] integral_pump_current_o,
  input wire logic prescaler_select_a_o,
  input wire logic prescaler_select_b_o,
  input wire logic main_cycle_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  logic [15:0] base;
  logic [15:0] fast;
  logic [1:0] sel;
  assign base = {8'h00, pump_cfg_i.gain_code};
  // Widened so code 3 does not wrap to a shift of zero
  assign fast = base << ({1'b0, pump_cfg_i.speed_code} + 3'h1);
  assign sel = {prescaler_select_b_o, prescaler_select_a_o};
  sequence s_speed;
    $rose(strobe_i) && word_a_sel_i ##1 (strobe_i && $stable(pump_cfg_i))[*2];
  endsequence
  a_normal_gain: assert property (
    (!strobe_i && $stable(pump_cfg_i))[*3] |-> proportional_pump_current_o == base)
    else $error("base current wrong");
  a_normal_int_off: assert property (
    !strobe_i[*3] |-> integral_pump_current_o == 16'h0000)
    else $error("integral current in normal mode");
  a_speed_scale: assert property (s_speed |-> proportional_pump_current_o == fast)
    else $error("speed-up current wrong");
  a_speed_int: assert property (
    s_speed |-> integral_pump_current_o == fast * {12'h000, pump_cfg_i.int_mult})
    else $error("integral current wrong");
  a_plain_rise: assert property (
    $rose(strobe_i) && !word_a_sel_i ##1 strobe_i[*2] |-> integral_pump_current_o == 16'h0000)
    else $error("speed-up without word A");
  a_aux_standby: assert property (aux_standby_i[*3] |-> aux_pump_out_o == 2'b00)
    else $error("aux pump active in standby");
  a_first_at_cycle: assert property (main_cycle_o |-> sel == synth_pkg::SEL_FIRST)
    else $error("cycle end without first ratio");
  a_cycle_single: assert property (main_cycle_o |=> !main_cycle_o)
    else $error("cycle pulse too long");
  a_sel_on_edge: assert property (!$stable(sel) |-> $past(prescaler_edge_i))
    else $error("select moved without prescaler edge");
  cover property (s_speed);
  cover property (sel == synth_pkg::SEL_FOURTH);
  cover property (main_cycle_o);
endmodule

bind dual_pll_divider_core dual_pll_divider_core_sva u_dual_pll_divider_core_sva (.*);

// ---- test/prescaler_model.sv ----
module prescaler_model (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic prescaler_select_a_i,
  input wire logic prescaler_select_b_o_i,
  output logic prescaler_edge_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt;
  // Spacing 5..8 clocks per output cycle tracks the selected ratio
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt <= 4'h0;
      prescaler_edge_o <= 1'b0;
    end
    else
    begin
      prescaler_edge_o <= run_i && cnt == 4'h0;
      cnt <= (cnt == 4'h0) ? {2'h1, prescaler_select_a_i, prescaler_select_b_o_i} : cnt - 4'h1;
    end
  end
endmodule

// ---- test/tb_dual_pll_divider_core.sv ----
module tb_dual_pll_divider_core;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic aux_clk_en_i = 1'b0;
  logic [11:0] aux_ratio_i = 12'h003;
  logic aux_standby_i = 1'b0;
  logic [3:0] ref_taps_i = 4'h0;
  logic prescaler_edge_i;
  synth_pkg::main_cfg_t main_cfg_i = '0;
  logic fractional_i = 1'b0;
  synth_pkg::pump_cfg_t pump_cfg_i = '0;
  logic strobe_i = 1'b0;
  logic word_a_sel_i = 1'b0;
  logic run = 1'b1;
  logic aux_run = 1'b0;
  logic ref_run = 1'b1;
  synth_pkg::pump_t aux_pump;
  synth_pkg::pump_t prop_pump;
  synth_pkg::pump_t int_pump;
  logic [15:0] prop_cur;
  logic [15:0] int_cur;
  logic sel_a;
  logic sel_b;
  logic main_cycle;
  logic aux_cycle;
  logic [15:0] tally [4];
  int fail_count = 0;
  int cmp_count = 0;
  dual_pll_divider_core u_dual_pll_divider_core (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .aux_clk_en_i(aux_clk_en_i), .aux_ratio_i(aux_ratio_i), .aux_standby_i(aux_standby_i),
    .ref_taps_i(ref_taps_i), .aux_tap_sel_i(2'h2), .main_tap_sel_i(2'h3),
    .prescaler_edge_i(prescaler_edge_i), .main_cfg_i(main_cfg_i), .fractional_i(fractional_i),
    .pump_cfg_i(pump_cfg_i), .strobe_i(strobe_i), .word_a_sel_i(word_a_sel_i),
    .aux_pump_out_o(aux_pump), .proportional_pump_out_o(prop_pump),
    .integral_pump_out_o(int_pump),
    .proportional_pump_current_o(prop_cur), .integral_pump_current_o(int_cur),
    .prescaler_select_a_o(sel_a), .prescaler_select_b_o(sel_b), .main_cycle_o(main_cycle),
    .aux_cycle_o(aux_cycle));
  prescaler_model u_prescaler_model (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .run_i(run),
    .prescaler_select_a_i(sel_a), .prescaler_select_b_o_i(sel_b),
    .prescaler_edge_o(prescaler_edge_i));
  initial
  begin
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i)
  begin
    ref_taps_i <= ref_run ? ref_taps_i + 4'h1 : ref_taps_i;
    aux_clk_en_i <= aux_run && !aux_clk_en_i;
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Edges tallied per select, from now through n cycle-end pulses
  task automatic tally_cycles(input int n);
    tally = '{default: 16'h0000};
    repeat (n)
    begin
      do
      begin
        @(posedge ref_clk_i);
        if (fractional_i)
          fractional_i <= 1'b0;
        if (prescaler_edge_i)
          tally[{sel_b, sel_a}]++;
      end
      while (!main_cycle);
    end
  endtask
  task automatic t_mode(input logic [1:0] m, input logic [11:0] n1, input logic [7:0] n2,
      input logic [3:0] e3, input logic [3:0] e4, input logic [15:0] x [4]);
    rst_i <= 1'b1;
    main_cfg_i <= '{m, n1, n2, e3, e4};
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    tally_cycles(1);
    tally_cycles(1);
    for (int i = 0; i < 4; i++)
      check(tally[i], x[i]);
  endtask
  task automatic t_frac;
    fractional_i <= 1'b1;
    tally_cycles(2);
    check(tally[0], 16'h0009);
    check(tally[1], 16'h0007);
  endtask
  task automatic t_pump;
    for (int l = 0; l < 4; l++)
    begin
      pump_cfg_i <= '{8'hA5, l[1:0], 4'hF};
      word_a_sel_i <= 1'b1;
      repeat (3) @(posedge ref_clk_i);
      check(prop_cur, 16'h00A5);
      check(int_cur, 16'h0000);
      strobe_i <= 1'b1;
      repeat (3) @(posedge ref_clk_i);
      check(prop_cur, 16'h00A5 << (l + 1));
      check(int_cur, (16'h00A5 << (l + 1)) * 16'h000F);
      strobe_i <= 1'b0;
    end
    word_a_sel_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    strobe_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    check(int_cur, 16'h0000);
    strobe_i <= 1'b0;
  endtask
  task automatic t_aux(input logic [11:0] r);
    logic [15:0] n = 16'h0000;
    aux_ratio_i <= r;
    aux_run <= 1'b1;
    repeat (2) @(posedge ref_clk_i iff aux_cycle);
    do
    begin
      @(posedge ref_clk_i);
      n += {15'h0000, aux_clk_en_i};
    end
    while (!aux_cycle);
    check(n, {4'h0, r});
  endtask
  task automatic t_standby_dir;
    logic [15:0] n = 16'h0000;
    aux_ratio_i <= 12'h003;
    aux_standby_i <= 1'b1;
    repeat (40) @(posedge ref_clk_i) n += {15'h0000, aux_cycle};
    check(n, 16'h0000);
    aux_standby_i <= 1'b0;
    aux_run <= 1'b0;
    run <= 1'b0;
    repeat (60) @(posedge ref_clk_i);
    check(aux_pump, 2'b10);
    check(prop_pump, 2'b10);
    check(int_pump, 2'b00);
    ref_run <= 1'b0;
    aux_run <= 1'b1;
    run <= 1'b1;
    repeat (200) @(posedge ref_clk_i);
    check(aux_pump, 2'b01);
    check(prop_pump, 2'b01);
  endtask
  initial
  begin
    repeat (60000) @(posedge ref_clk_i);
    fail_count++;
    conclude();
  end
  initial
  begin
    repeat (16) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    t_mode(2'h2, 12'h003, 8'h00, 4'h1, 4'h3, '{16'h3, 16'h10, 16'h1, 16'h2});
    t_mode(2'h1, 12'h004, 8'h02, 4'h5, 4'h0, '{16'h4, 16'h2, 16'h3, 16'h0});
    t_mode(2'h0, 12'h005, 8'h03, 4'h0, 4'h0, '{16'h5, 16'h3, 16'h0, 16'h0});
    t_frac();
    t_pump();
    t_aux(12'h003);
    t_aux(12'hFFF);
    t_standby_dir();
    conclude();
  end
endmodule
